/* File: core/cbs_pkg.sv */
// Package: constants, register map and pin bundle of the bus cycle sequencer
package cbs_pkg;

	// ****************************************
	// Register byte offsets
	// ****************************************
	localparam logic [7:0] CBS_OFF_CONTROL = 8'h00;
	localparam logic [7:0] CBS_OFF_ADDRESS = 8'h04;
	localparam logic [7:0] CBS_OFF_WRITE_DATA = 8'h08;
	localparam logic [7:0] CBS_OFF_READ_DATA = 8'h0C;
	localparam logic [7:0] CBS_OFF_STATUS = 8'h10;
	localparam logic [7:0] CBS_OFF_PROGRAM_COUNTER = 8'h14;
	localparam logic [7:0] CBS_OFF_VECTOR_PAGE = 8'h18;
	localparam logic [7:0] CBS_OFF_REFRESH = 8'h1C;
	localparam logic [7:0] CBS_OFF_INTERRUPT = 8'h20;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int CBS_CTRL_KIND_LSB = 0;
	localparam int CBS_CTRL_LEN_LSB = 2;
	localparam int CBS_CTRL_START_BIT = 8;
	localparam int CBS_STAT_BUSY_BIT = 0;
	localparam int CBS_STAT_GRANT_BIT = 1;
	localparam int CBS_STAT_DONE_BIT = 2;
	localparam int CBS_STAT_WAIT_BIT = 3;
	localparam int CBS_STAT_PENDING_BIT = 4;
	localparam int CBS_INT_ENABLE_BIT = 0;
	localparam int CBS_INT_MODE_LSB = 1;

	// ****************************************
	// Cycle kinds and lengths in T states
	// ****************************************
	localparam logic [1:0] CBS_KIND_FETCH = 2'h0;
	localparam logic [1:0] CBS_KIND_READ = 2'h1;
	localparam logic [1:0] CBS_KIND_WRITE = 2'h2;
	localparam logic [2:0] CBS_FETCH_MIN = 3'h4;
	localparam logic [2:0] CBS_FETCH_MAX = 3'h6;
	localparam logic [2:0] CBS_DATA_MIN = 3'h3;
	localparam logic [2:0] CBS_DATA_MAX = 3'h5;
	localparam logic [2:0] CBS_REFRESH_STATE = 3'h4;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [15:0] CBS_PC_RESET = 16'h0000;
	localparam logic [7:0] CBS_VPAGE_RESET = 8'h00;
	localparam logic [7:0] CBS_REFRESH_RESET = 8'h00;
	localparam logic [1:0] CBS_MODE_RESET = 2'h0;
	localparam logic [2:0] CBS_LEN_RESET = 3'h4;

	// ****************************************
	// Pin bundle toward memory and bus master
	// ****************************************
	typedef struct packed {
		logic [15:0] address;
		logic address_oe_n;
		logic [7:0] data;
		logic data_oe_n;
		logic memory_request_strobe_n;
		logic read_strobe_n;
		logic write_strobe_n;
		logic control_oe_n;
		logic refresh_indicator_n;
		logic opcode_fetch_cycle_n;
		logic bus_hold_grant_n;
	} cbs_pins_type;

	localparam cbs_pins_type CBS_PINS_RESET = '{
		address: 16'h0000,
		address_oe_n: 1'b1,
		data: 8'h00,
		data_oe_n: 1'b1,
		memory_request_strobe_n: 1'b1,
		read_strobe_n: 1'b1,
		write_strobe_n: 1'b1,
		control_oe_n: 1'b1,
		refresh_indicator_n: 1'b1,
		opcode_fetch_cycle_n: 1'b1,
		bus_hold_grant_n: 1'b1
	};

endpackage

/* File: core/cbs_sequencer.sv */
// Bus cycle sequencer: fetch, memory read/write, wait and hold, with APB control
//
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/1ps

// ****************************************
// Input synchroniser with agreement filter
// ****************************************
module cbs_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '1
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Data
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1 <= INIT;
			s2 <= INIT;
			s3 <= INIT;
		end else begin
			s1 <= din;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// A bit moves only when the second and third stage agree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dout <= INIT;
		end else begin
			dout <= (s3 & ~(s2 ^ s3)) | (dout & (s2 ^ s3));
		end
	end
endmodule

// Summary of operation
// - Reset clears the program counter to zero.
// - Reset clears the interrupt enable flag and selects interrupt mode 0.
// - Reset clears the vector page and refresh counter to 00.
// - During reset buses float, controls inactive, no refresh.
// - Hold request floats address, data and controls after the current cycle.
// - Grant goes low only after the buses have been floated.
// - No refresh while waiting or while the bus is granted.
// - Opcode fetch lasts four to six states, plus waits.
// - Later cycles last three to five states, plus waits.
// - Fetch drives program counter first, strobes half a state later.
// - Fetch captures data at third-state rise and drops read strobes there.
// - Third and fourth fetch states: refresh address, indicator, memory request pulse.
// - Read strobe stays inactive during refresh.
// - Wait sampled at falling edge of second and wait states.
// - Memory read and write take three to five states; reads strobe like fetch but hold strobes to the end of the third state.
// - Write: memory request after address, write strobe after stable data.
// - Write strobe drops half a state before address or data change.
// - Read and write cycles lengthen by waits exactly like fetch.
// - Read and write strobes are never active together.
// - Refresh drives address bit 7 low and vector page on top byte.
module cbs_sequencer
	import cbs_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Bus pins
	output cbs_pins_type bus_pins,
	input wire logic [7:0] data_in,
	input wire logic wait_n,
	input wire logic bus_hold_request_n
);

	// ****************************************
	// Declarations
	// ****************************************
	typedef enum logic [2:0] {
		CBS_IDLE, CBS_T1, CBS_T2, CBS_TW, CBS_T3, CBS_TX, CBS_HOLD
	} cbs_state_type;

	cbs_state_type state;
	cbs_state_type next_state;
	logic phase;
	logic [2:0] tcount;
	logic [2:0] next_tcount;
	logic [1:0] kind;
	logic [2:0] len;
	logic [15:0] cyc_addr;
	logic [7:0] cyc_data;
	logic wait_seen;
	logic hold_seen;
	logic last_state;
	logic cycle_end;
	logic launch;
	logic fetch_done;
	logic [7:0] data_sync;
	logic wait_sync_n;
	logic hold_sync_n;
	cbs_pins_type next_pins;
	// Software registers
	logic [1:0] ctrl_kind;
	logic [2:0] ctrl_len;
	logic pending;
	logic [15:0] addr_reg;
	logic [7:0] wdata_reg;
	logic [7:0] rdata_reg;
	logic done_flag;
	logic [15:0] program_counter;
	logic [7:0] vector_page;
	logic [7:0] refresh_counter;
	logic interrupt_enable_flag;
	logic [1:0] interrupt_mode;
	logic apb_take;
	logic wr_en;
	logic [31:0] rd_mux;
	logic rd_hit;
	logic capture_now;
	logic [2:0] capture_pipe;

	// ****************************************
	// Pin synchronisers
	// ****************************************
	// Data passes the same filter; memories must hold it steady while read strobe is low
	cbs_sync #(.W(8), .INIT(8'hFF)) u_sync_data (
		.pclk(pclk),
		.presetn(presetn),
		.din(data_in),
		.dout(data_sync)
	);

	cbs_sync #(.W(1), .INIT(1'b1)) u_sync_wait (
		.pclk(pclk),
		.presetn(presetn),
		.din(wait_n),
		.dout(wait_sync_n)
	);

	cbs_sync #(.W(1), .INIT(1'b1)) u_sync_hold (
		.pclk(pclk),
		.presetn(presetn),
		.din(bus_hold_request_n),
		.dout(hold_sync_n)
	);

	// ****************************************
	// Cycle sequencer
	// ****************************************
	// Each T state is two pclk cycles: phase 0 high half, phase 1 low half
	assign last_state = ((state == CBS_T3) && (len == CBS_DATA_MIN)) ||
		((state == CBS_TX) && (tcount == len));
	assign cycle_end = last_state && phase;

	always_comb begin
		next_state = state;
		next_tcount = tcount;
		case (state)
			CBS_IDLE: begin
				if (!hold_sync_n) begin
					next_state = CBS_HOLD;
				end else if (pending) begin
					next_state = CBS_T1;
					next_tcount = 3'h1;
				end
			end
			CBS_T1: begin
				if (phase) begin
					next_state = CBS_T2;
					next_tcount = 3'h2;
				end
			end
			CBS_T2, CBS_TW: begin
				if (phase) begin
					next_state = wait_seen ? CBS_TW : CBS_T3;
					next_tcount = wait_seen ? 3'h2 : 3'h3;
				end
			end
			CBS_T3, CBS_TX: begin
				if (cycle_end) begin
					if (hold_seen) begin
						next_state = CBS_HOLD;
					end else if (pending) begin
						next_state = CBS_T1;
						next_tcount = 3'h1;
					end else begin
						next_state = CBS_IDLE;
					end
				end else if (phase) begin
					next_state = CBS_TX;
					next_tcount = tcount + 3'h1;
				end
			end
			CBS_HOLD: begin
				if (hold_sync_n) begin
					next_state = CBS_IDLE;
				end
			end
			default: begin
				next_state = CBS_IDLE;
			end
		endcase
	end

	assign launch = (next_state == CBS_T1) && (state != CBS_T1);
	assign fetch_done = cycle_end && (kind == CBS_KIND_FETCH);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= CBS_IDLE;
			phase <= 1'b0;
			tcount <= 3'h0;
		end else begin
			state <= next_state;
			tcount <= next_tcount;
			phase <= (next_state == CBS_IDLE || next_state == CBS_HOLD) ? 1'b0 :
				(launch ? 1'b0 : ~phase);
		end
	end

	// Cycle parameters frozen at launch
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			kind <= CBS_KIND_FETCH;
			len <= CBS_LEN_RESET;
			cyc_addr <= 16'h0000;
			cyc_data <= 8'h00;
		end else if (launch) begin
			kind <= ctrl_kind;
			cyc_addr <= (ctrl_kind == CBS_KIND_FETCH) ? program_counter : addr_reg;
			cyc_data <= wdata_reg;
			// Out-of-range lengths are clamped rather than refused
			if (ctrl_kind == CBS_KIND_FETCH) begin
				len <= (ctrl_len < CBS_FETCH_MIN) ? CBS_FETCH_MIN :
					((ctrl_len > CBS_FETCH_MAX) ? CBS_FETCH_MAX : ctrl_len);
			end else begin
				len <= (ctrl_len < CBS_DATA_MIN) ? CBS_DATA_MIN :
					((ctrl_len > CBS_DATA_MAX) ? CBS_DATA_MAX : ctrl_len);
			end
		end
	end

	// Wait at falling edge of T2/Tw; hold at falling edge of the last state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wait_seen <= 1'b0;
			hold_seen <= 1'b0;
		end else begin
			if ((state == CBS_T2 || state == CBS_TW) && !phase) begin
				wait_seen <= !wait_sync_n;
			end
			if (last_state && !phase) begin
				hold_seen <= !hold_sync_n;
			end else if (state == CBS_HOLD) begin
				hold_seen <= 1'b0;
			end
		end
	end

	// ****************************************
	// Pin decode, registered one pclk later
	// ****************************************
	always_comb begin
		logic refresh_slot;
		logic strobe_slot;
		refresh_slot = 1'b0;
		strobe_slot = 1'b0;
		next_pins = CBS_PINS_RESET;
		strobe_slot = (state == CBS_T1 && phase) || state == CBS_T2 || state == CBS_TW;
		// Refresh only in T3/T4 of a fetch, never in wait or hold
		refresh_slot = (kind == CBS_KIND_FETCH) && (state == CBS_T3 ||
			(state == CBS_TX && tcount == CBS_REFRESH_STATE));
		if (state != CBS_HOLD) begin
			next_pins.address_oe_n = 1'b0;
			next_pins.control_oe_n = 1'b0;
			next_pins.address = cyc_addr;
		end else begin
			next_pins.bus_hold_grant_n = !bus_pins.control_oe_n;
			next_pins.address = bus_pins.address;
		end
		case (kind)
			CBS_KIND_FETCH: begin
				next_pins.opcode_fetch_cycle_n = !(state == CBS_T1 || state == CBS_T2 ||
					state == CBS_TW);
				next_pins.read_strobe_n = !strobe_slot;
				next_pins.memory_request_strobe_n = !(strobe_slot ||
					(state == CBS_T3 && phase) ||
					(state == CBS_TX && tcount == CBS_REFRESH_STATE && !phase));
				if (refresh_slot) begin
					next_pins.refresh_indicator_n = 1'b0;
					next_pins.address = {vector_page, 1'b0, refresh_counter[6:0]};
				end
			end
			CBS_KIND_READ: begin
				next_pins.read_strobe_n = !(strobe_slot || state == CBS_T3);
				next_pins.memory_request_strobe_n = !(strobe_slot || state == CBS_T3);
			end
			CBS_KIND_WRITE: begin
				next_pins.memory_request_strobe_n = !(strobe_slot || state == CBS_T3);
				next_pins.write_strobe_n = !((state == CBS_T2 && phase) ||
					state == CBS_TW || (state == CBS_T3 && !phase));
				if (state == CBS_T1 || state == CBS_T2 || state == CBS_TW || state == CBS_T3) begin
					next_pins.data_oe_n = 1'b0;
					next_pins.data = cyc_data;
				end
			end
			default: begin
				next_pins.address = cyc_addr;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus_pins <= CBS_PINS_RESET;
		end else begin
			bus_pins <= next_pins;
		end
	end

	// ****************************************
	// APB slave, one wait cycle per access
	// ****************************************
	assign apb_take = psel && penable && pready;
	assign wr_en = apb_take && pwrite;

	always_comb begin
		rd_mux = 32'h0000_0000;
		rd_hit = 1'b1;
		case (paddr)
			CBS_OFF_CONTROL: begin
				rd_mux[CBS_CTRL_KIND_LSB +: 2] = ctrl_kind;
				rd_mux[CBS_CTRL_LEN_LSB +: 3] = ctrl_len;
				rd_mux[CBS_CTRL_START_BIT] = pending;
			end
			CBS_OFF_ADDRESS: rd_mux[15:0] = addr_reg;
			CBS_OFF_WRITE_DATA: rd_mux[7:0] = wdata_reg;
			CBS_OFF_READ_DATA: rd_mux[7:0] = rdata_reg;
			CBS_OFF_STATUS: begin
				rd_mux[CBS_STAT_BUSY_BIT] = (state != CBS_IDLE) && (state != CBS_HOLD);
				rd_mux[CBS_STAT_GRANT_BIT] = !bus_pins.bus_hold_grant_n;
				rd_mux[CBS_STAT_DONE_BIT] = done_flag;
				rd_mux[CBS_STAT_WAIT_BIT] = (state == CBS_TW);
				rd_mux[CBS_STAT_PENDING_BIT] = pending;
			end
			CBS_OFF_PROGRAM_COUNTER: rd_mux[15:0] = program_counter;
			CBS_OFF_VECTOR_PAGE: rd_mux[7:0] = vector_page;
			CBS_OFF_REFRESH: rd_mux[7:0] = refresh_counter;
			CBS_OFF_INTERRUPT: begin
				rd_mux[CBS_INT_ENABLE_BIT] = interrupt_enable_flag;
				rd_mux[CBS_INT_MODE_LSB +: 2] = interrupt_mode;
			end
			default: rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && penable && !pready;
			prdata <= (psel && penable && !pready && !pwrite) ? rd_mux : 32'h0000_0000;
			pslverr <= psel && penable && !pready && !rd_hit;
		end
	end

	// ****************************************
	// Software registers
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_kind <= CBS_KIND_FETCH;
			ctrl_len <= CBS_LEN_RESET;
			addr_reg <= 16'h0000;
			wdata_reg <= 8'h00;
			vector_page <= CBS_VPAGE_RESET;
			interrupt_enable_flag <= 1'b0;
			interrupt_mode <= CBS_MODE_RESET;
		end else if (wr_en) begin
			case (paddr)
				CBS_OFF_CONTROL: begin
					ctrl_kind <= pwdata[CBS_CTRL_KIND_LSB +: 2];
					ctrl_len <= pwdata[CBS_CTRL_LEN_LSB +: 3];
				end
				CBS_OFF_ADDRESS: addr_reg <= pwdata[15:0];
				CBS_OFF_WRITE_DATA: wdata_reg <= pwdata[7:0];
				CBS_OFF_VECTOR_PAGE: vector_page <= pwdata[7:0];
				CBS_OFF_INTERRUPT: begin
					interrupt_enable_flag <= pwdata[CBS_INT_ENABLE_BIT];
					interrupt_mode <= pwdata[CBS_INT_MODE_LSB +: 2];
				end
				default: begin
					vector_page <= vector_page;
				end
			endcase
		end
	end

	// Start request: one cycle can be queued behind the running one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pending <= 1'b0;
		end else if (wr_en && paddr == CBS_OFF_CONTROL && pwdata[CBS_CTRL_START_BIT]) begin
			pending <= 1'b1;
		end else if (launch) begin
			pending <= 1'b0;
		end
	end

	// Completion flag: a cycle ending in the clearing write still sets it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_flag <= 1'b0;
		end else if (cycle_end) begin
			done_flag <= 1'b1;
		end else if (wr_en && paddr == CBS_OFF_STATUS && pwdata[CBS_STAT_DONE_BIT]) begin
			done_flag <= 1'b0;
		end
	end

	// Data synchroniser lags the pins; the capture point is delayed to match
	assign capture_now = (kind == CBS_KIND_FETCH && (state == CBS_T2 || state == CBS_TW) &&
		phase && !wait_seen) || (kind == CBS_KIND_READ && state == CBS_T3 && !phase);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			capture_pipe <= 3'h0;
		end else begin
			capture_pipe <= {capture_pipe[1:0], capture_now};
		end
	end

	// Opcode at T3 rise for a fetch, mid-T3 for a plain read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_reg <= 8'h00;
		end else if (capture_pipe[2]) begin
			rdata_reg <= data_sync;
		end
	end

	// Sequencer step wins; software writes while a fetch ends are dropped
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			program_counter <= CBS_PC_RESET;
		end else if (fetch_done) begin
			program_counter <= program_counter + 16'h0001;
		end else if (wr_en && paddr == CBS_OFF_PROGRAM_COUNTER) begin
			program_counter <= pwdata[15:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			refresh_counter <= CBS_REFRESH_RESET;
		end else if (fetch_done) begin
			refresh_counter <= {refresh_counter[7], refresh_counter[6:0] + 7'h01};
		end else if (wr_en && paddr == CBS_OFF_REFRESH) begin
			refresh_counter <= pwdata[7:0];
		end
	end

endmodule

/* File: test/cbs_sequencer_props.sv */
// Checker: pin timing properties of the bus cycle sequencer
`timescale 1ns/1ps
module cbs_sequencer_props
	import cbs_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Observed outputs
	input wire logic pready,
	input wire logic pslverr,
	input wire cbs_pins_type bus_pins
);
	wire req_n = bus_pins.memory_request_strobe_n;
	wire rd_n = bus_pins.read_strobe_n;
	wire wr_n = bus_pins.write_strobe_n;
	wire ref_n = bus_pins.refresh_indicator_n;
	wire gnt_n = bus_pins.bus_hold_grant_n;
	wire ftc_n = bus_pins.opcode_fetch_cycle_n;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ****************************************
	// Assertions
	// ****************************************
	strobe_excl_a: assert property (!(!rd_n && !wr_n))
		else $error("read and write strobes active together");
	grant_float_a: assert property (!gnt_n |->
		bus_pins.address_oe_n && bus_pins.data_oe_n && bus_pins.control_oe_n)
		else $error("grant given while pins driven");
	float_first_a: assert property ($fell(gnt_n) |-> $past(bus_pins.control_oe_n))
		else $error("grant before controls floated");
	grant_quiet_a: assert property (!gnt_n |-> ref_n)
		else $error("refresh while bus granted");
	refresh_noread_a: assert property (!ref_n |-> rd_n)
		else $error("read strobe during refresh");
	refresh_addr_a: assert property (!ref_n && !req_n |-> !bus_pins.address[7])
		else $error("refresh address bit 7 high");
	fetch_addr_a: assert property ($fell(req_n) && ref_n && !ftc_n |->
		!$past(ftc_n) && $stable(bus_pins.address))
		else $error("fetch strobe without settled address");
	read_pair_a: assert property ($fell(rd_n) |-> $fell(req_n))
		else $error("read strobe without memory request");
	refresh_pulse_a: assert property ($fell(ref_n) |->
		rd_n && req_n ##1 !req_n [*2] ##1 req_n && !ref_n)
		else $error("refresh pulse shape wrong");
	write_setup_a: assert property ($fell(wr_n) |->
		!req_n && !bus_pins.data_oe_n && $stable(bus_pins.data))
		else $error("write strobe before stable data");
	write_hold_a: assert property ($rose(wr_n) |->
		$stable(bus_pins.address) && $stable(bus_pins.data) && !bus_pins.data_oe_n)
		else $error("bus changed with write strobe");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	error_with_ready_a: assert property (pslverr |-> pready)
		else $error("slave error without ready");
endmodule

bind cbs_sequencer cbs_sequencer_props props (.pclk(pclk), .presetn(presetn),
	.pready(pready), .pslverr(pslverr), .bus_pins(bus_pins));

/* File: test/cbs_far_side.sv */
// Far-side model: memory with wait control and an external bus master
`timescale 1ns/1ps
module cbs_far_side
	import cbs_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Pins of the sequencer
	input wire cbs_pins_type bus_pins,
	output logic [7:0] data_in,
	output logic wait_n,
	output logic bus_hold_request_n,
	// Scenario controls
	input wire logic hold_req,
	input wire logic [7:0] stall,
	input wire logic stall_load
);
	logic [7:0] mem [0:255];
	logic [7:0] junk;
	logic [7:0] stall_left;
	int refresh_reads;
	wire sel = !bus_pins.control_oe_n && !bus_pins.memory_request_strobe_n;
	wire [7:0] loc = bus_pins.address[7:0];
	initial begin
		foreach (mem[i]) begin
			mem[i] = ~8'(i);
		end
	end
	// Released bus toggles so a stale byte never looks valid
	assign data_in = (sel && !bus_pins.read_strobe_n) ? mem[loc] : junk;
	// Slow memory holds wait until its stall has run out
	assign wait_n = (stall_left == 8'h00);
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			junk <= 8'h5A;
			stall_left <= 8'h00;
			bus_hold_request_n <= 1'b1;
			refresh_reads <= 0;
		end else begin
			junk <= ~junk;
			bus_hold_request_n <= !hold_req;
			if (stall_load) begin
				stall_left <= stall;
			end else if (sel && stall_left != 8'h00) begin
				stall_left <= stall_left - 8'h01;
			end
			if (sel && !bus_pins.write_strobe_n && !bus_pins.data_oe_n) begin
				mem[loc] <= bus_pins.data;
			end
			// Refresh keyed on the request strobe, not the indicator alone
			if (sel && !bus_pins.refresh_indicator_n) begin
				refresh_reads <= refresh_reads + 1;
			end
		end
	end
endmodule

/* File: test/cbs_sequencer_tb.sv */
// Testbench: register access and bus cycles of the sequencer
`timescale 1ns/1ps
module cbs_sequencer_tb
	import cbs_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	cbs_pins_type bus_pins;
	logic [7:0] data_in;
	logic wait_n;
	logic bus_hold_request_n;
	logic hold_req = 1'b0;
	logic [7:0] stall = 8'h00;
	logic stall_load = 1'b0;
	int errors = 0;
	int check_count = 0;
	int cyc = 0;
	int last_fall = 0;
	int gap = 0;
	int req_cnt = 0;
	int base;
	logic act_prev = 1'b0;
	logic [15:0] ref_addr = 16'h0;
	logic [31:0] r;
	logic e;
	logic [1:0] kinds [6] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2};
	logic [2:0] lens [6] = '{3'h4, 3'h6, 3'h3, 3'h5, 3'h3, 3'h5};

	cbs_sequencer dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .bus_pins(bus_pins), .data_in(data_in),
		.wait_n(wait_n), .bus_hold_request_n(bus_hold_request_n));
	cbs_far_side far (.pclk(pclk), .presetn(presetn), .bus_pins(bus_pins),
		.data_in(data_in), .wait_n(wait_n), .bus_hold_request_n(bus_hold_request_n),
		.hold_req(hold_req), .stall(stall), .stall_load(stall_load));

	initial begin
		forever #12.5 pclk = ~pclk;
	end
	// ****************************************
	// Pin monitor and timeout
	// ****************************************
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			finish_test();
		end
		if (!bus_pins.memory_request_strobe_n && bus_pins.refresh_indicator_n) begin
			req_cnt++;
			if (!act_prev) begin
				gap = cyc - last_fall;
				last_fall = cyc;
			end
		end
		if (!bus_pins.memory_request_strobe_n && !bus_pins.refresh_indicator_n) begin
			ref_addr = bus_pins.address;
		end
		act_prev = !bus_pins.memory_request_strobe_n && bus_pins.refresh_indicator_n;
	end
	// ****************************************
	// Tasks
	// ****************************************
	task automatic finish_test();
		if (errors == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %s expected %0h seen %0h", name, exp, seen);
		end
	endtask
	// One APB transfer; a gap cycle precedes each setup
	task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		penable <= 1'b0;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] x, input string n);
		xfer(a, 1'b0, 32'h0);
		check(n, 64'(r), 64'(x));
	endtask
	function automatic logic [31:0] ctl(input logic [1:0] k, input logic [2:0] l);
		return {23'h0, 1'b1, 3'h0, l, k};
	endfunction
	task automatic wait_idle();
		int n;
		n = 0;
		do begin
			xfer(CBS_OFF_STATUS, 1'b0, 32'h0);
			n++;
		end while ((r[CBS_STAT_BUSY_BIT] !== 1'b0 || r[CBS_STAT_PENDING_BIT] !== 1'b0 ||
			r[CBS_STAT_DONE_BIT] !== 1'b1) && n < 300);
		check("idle reached", 64'(n < 300), 64'(1'b1));
		xfer(CBS_OFF_STATUS, 1'b1, 32'h4);
	endtask
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		repeat (3) @(posedge pclk);
		check("pins in reset", 64'(bus_pins), 64'(CBS_PINS_RESET));
		presetn <= 1'b1;
		rd_chk(CBS_OFF_PROGRAM_COUNTER, 32'h0, "counter reset");
		rd_chk(CBS_OFF_INTERRUPT, 32'h0, "interrupt reset");
		rd_chk(CBS_OFF_VECTOR_PAGE, 32'h0, "page reset");
		rd_chk(CBS_OFF_REFRESH, 32'h0, "refresh reset");
		rd_chk(CBS_OFF_CONTROL, 32'h10, "control reset");
		xfer(CBS_OFF_INTERRUPT, 1'b1, 32'h5);
		rd_chk(CBS_OFF_INTERRUPT, 32'h5, "interrupt store");
		xfer(8'h40, 1'b1, 32'h0);
		check("unmapped error", 64'(e), 64'(1'b1));
		// Fetch at a wrapping refresh count
		xfer(CBS_OFF_PROGRAM_COUNTER, 1'b1, 32'h127F);
		xfer(CBS_OFF_VECTOR_PAGE, 1'b1, 32'hA6);
		xfer(CBS_OFF_REFRESH, 1'b1, 32'hFF);
		base = req_cnt;
		xfer(CBS_OFF_CONTROL, 1'b1, ctl(CBS_KIND_FETCH, 3'h4));
		wait_idle();
		check("fetch strobe span", 64'(req_cnt - base), 64'(3));
		check("refresh address", 64'(ref_addr), 64'(16'hA67F));
		rd_chk(CBS_OFF_READ_DATA, 32'h80, "fetched byte");
		rd_chk(CBS_OFF_REFRESH, 32'h80, "refresh step");
		// Back-to-back cycles: strobe spacing gives the length
		xfer(CBS_OFF_ADDRESS, 1'b1, 32'h0342);
		xfer(CBS_OFF_WRITE_DATA, 1'b1, 32'h3C);
		foreach (lens[i]) begin
			xfer(CBS_OFF_CONTROL, 1'b1, ctl(kinds[i], lens[i]));
			xfer(CBS_OFF_CONTROL, 1'b1, ctl(kinds[i], lens[i]));
			wait_idle();
			check("cycle spacing", 64'(gap), 64'(2 * lens[i]));
		end
		check("written byte", 64'(far.mem[8'h42]), 64'(8'h3C));
		// Read stretched by a slow memory
		stall <= 8'h06;
		stall_load <= 1'b1;
		@(posedge pclk);
		stall_load <= 1'b0;
		base = req_cnt;
		xfer(CBS_OFF_CONTROL, 1'b1, ctl(CBS_KIND_READ, 3'h3));
		wait_idle();
		check("wait stretch", 64'(req_cnt - base > 5), 64'(1'b1));
		rd_chk(CBS_OFF_READ_DATA, 32'h3C, "stalled read");
		// Hold request during a fetch, then a start while held
		xfer(CBS_OFF_CONTROL, 1'b1, ctl(CBS_KIND_FETCH, 3'h4));
		hold_req <= 1'b1;
		for (int n = 0; n < 100 && bus_pins.bus_hold_grant_n !== 1'b0; n++) @(posedge pclk);
		check("grant pin", 64'(bus_pins.bus_hold_grant_n), 64'(1'b0));
		rd_chk(CBS_OFF_STATUS, 32'h6, "cycle ended before grant");
		base = far.refresh_reads;
		xfer(CBS_OFF_CONTROL, 1'b1, ctl(CBS_KIND_FETCH, 3'h4));
		repeat (4) xfer(CBS_OFF_STATUS, 1'b0, 32'h0);
		check("held start pending", 64'(r[CBS_STAT_PENDING_BIT]), 64'(1'b1));
		check("no refresh in hold", 64'(far.refresh_reads - base), 64'(0));
		hold_req <= 1'b0;
		wait_idle();
		rd_chk(CBS_OFF_PROGRAM_COUNTER, 32'h1286, "counter after fetches");
		finish_test();
	end
endmodule
